// >>> pkg/tob_defs.svh
// constants for the trim option bank: addresses, fields, resets, timing
// What this block does
// RULE1 - trim 00h holds adc reference trim byte
// RULE2 - trim 01h holds reserved adc comparator byte
// RULE3 - trim 02h holds oscillator trim byte
// RULE4 - trim 03h holds brownout level in bits
// RULE5 - trim 06h holds filter byte, reset 44h
// RULE6 - divide select gives full or quarter rate
// RULE7 - filter mode selects which glitches suppressed
// RULE8 - delay code sets 5 to 25 ns
// RULE9 - software leaves factory trim values unchanged
// RULE10 - software writes index, then accesses data
// RULE11 - reset performs 43 flash reads, six-bit counter
// RULE12 - reserved bits forced to one on write
`ifndef TOB_DEFS_SVH
`define TOB_DEFS_SVH
`define TOB_IDX_ADDR 8'h00
`define TOB_DATA_ADDR 8'h01
`define TOB_TRIM_ADC_REF 5'h00
`define TOB_TRIM_ADCCMP 5'h01
`define TOB_TRIM_OSC 5'h02
`define TOB_TRIM_BROWN 5'h03
`define TOB_TRIM_CLKFLT 5'h06
`define TOB_INFO_BASE 6'h20
`define TOB_LOAD_COUNT 6'h2b
`define TOB_CLKFLT_RESET 8'h44
`define TOB_CLKFLT_RSVD 8'h44
`define TOB_BROWN_RSVD 8'hf8
`define TOB_DIV_BIT 7
`define TOB_DLY_B0 5
`define TOB_DLY_B1 4
`define TOB_DLY_B2 3
`define TOB_MODE_B1 1
`define TOB_MODE_B0 0
`define TOB_CLK_NS 4
`endif

// >>> pkg/tob_pkg.sv
// types for the trim option bank
package tob_pkg;
  typedef enum logic [1:0]
  {
    TOB_LOAD = 2'b00,
    TOB_RUN = 2'b01
  } tob_state_t;
  typedef enum logic [1:0]
  {
    TOB_NOFILT = 2'b00,
    TOB_LOWGL = 2'b01,
    TOB_HIGHGL = 2'b10,
    TOB_BOTH = 2'b11
  } tob_mode_t;
endpackage

// >>> pkg/tob_filt_if.sv
// configuration path from the trim bank to the clock filter
`timescale 1ns/100ps
interface tob_filt_if;
  logic quarter_rate_select;
  tob_pkg::tob_mode_t mode;
  logic [2:0] delay_code;
  modport bank (output quarter_rate_select, output mode, output delay_code);
  modport filt (input quarter_rate_select, input mode, input delay_code);
endinterface

// >>> rtl/tob_clock_glitch_filter.sv
// clock glitch filter with optional divide by four
`timescale 1ns/100ps
`include "tob_defs.svh"
module tob_clock_glitch_filter
(
  input wire logic clock,
  input wire logic rst,
  tob_filt_if.filt cfg,
  input wire logic clk_in,
  output logic clk_out
);
  import tob_pkg::*;
  localparam int unsigned STEP = `TOB_CLK_NS;
  logic s1_reg, s2_reg, lvl_reg, lvl_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [1:0] div_reg, div_next;
  logic out_reg, out_next;
  logic [3:0] limit;
  logic may_rise, may_fall;
  // glitch width in ns rounded down to cycles; at least one
  always_comb
  begin
    unique case (cfg.delay_code) // RULE8
      3'd0: limit = 4'(5 / STEP);
      3'd1: limit = 4'(7 / STEP);
      3'd2: limit = 4'(9 / STEP);
      3'd3: limit = 4'(11 / STEP);
      3'd4: limit = 4'(13 / STEP);
      3'd5: limit = 4'(17 / STEP);
      3'd6: limit = 4'(20 / STEP);
      3'd7: limit = 4'(25 / STEP);
    endcase
  end
  // a low pulse on high is a fall that must persist, and vice versa
  assign may_fall = cfg.mode == TOB_LOWGL || cfg.mode == TOB_BOTH; // RULE7
  assign may_rise = cfg.mode == TOB_HIGHGL || cfg.mode == TOB_BOTH; // RULE7
  always_comb
  begin
    lvl_next = lvl_reg;
    cnt_next = 4'h0;
    if (s2_reg != lvl_reg)
    begin
      if ((s2_reg && !may_rise) || (!s2_reg && !may_fall)
          || cnt_reg >= limit)
        lvl_next = s2_reg;
      else
        cnt_next = cnt_reg + 4'h1;
    end
    div_next = div_reg;
    if (lvl_next && !lvl_reg)
      div_next = div_reg + 2'h1;
    // quarter rate toggles output every second filtered rise
    out_next = cfg.quarter_rate_select ? div_reg[1] : lvl_reg; // RULE6
  end
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      lvl_reg <= 1'b0;
      cnt_reg <= 4'h0;
      div_reg <= 2'h0;
      out_reg <= 1'b0;
    end
    else
    begin
      s1_reg <= clk_in;
      s2_reg <= s1_reg;
      lvl_reg <= lvl_next;
      cnt_reg <= cnt_next;
      div_reg <= div_next;
      out_reg <= out_next;
    end
  end
  assign clk_out = out_reg;
endmodule

// >>> rtl/tob_trim_option_bank.sv
// trim option bank: reset-time flash load and indirect register pair
`timescale 1ns/100ps
`include "tob_defs.svh"
module tob_trim_option_bank
(
  input wire logic clock,
  input wire logic rst,
  input wire logic reg_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic [5:0] flash_addr,
  output logic flash_rd,
  input wire logic [7:0] flash_data,
  output logic load_done,
  input wire logic clk_in,
  output logic clk_out,
  output logic [3:0] adc_reference_trim_field,
  output logic [7:0] adc_comparator_trim,
  output logic [7:0] precision_osc_trim_field,
  output logic [2:0] brownout_level_field
);
  import tob_pkg::*;
  logic [7:0] trim_mem_reg [0:31];
  logic [7:0] trim_wval;
  logic [4:0] trim_index_register_reg, trim_index_register_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [5:0] cnt_reg, cnt_next;
  logic [5:0] cnt_prev_reg;
  logic prev_rd_reg;
  tob_state_t state_reg, state_next;
  logic wr_data, wr_idx;
  tob_filt_if filt_cfg ();
  logic [7:0] clkflt;
  logic clkflt_loaded_reg;

  assign wr_idx = reg_sel && reg_wr && reg_addr == `TOB_IDX_ADDR;
  assign wr_data = reg_sel && reg_wr && reg_addr == `TOB_DATA_ADDR
    && state_reg == TOB_RUN;

  // 43 reads, one a clock; counts 32..42 fall in the info page
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    unique case (state_reg)
      TOB_LOAD:
      begin
        if (cnt_reg == `TOB_LOAD_COUNT - 6'h1) // RULE11
          state_next = TOB_RUN;
        else
          cnt_next = cnt_reg + 6'h1; // RULE11
      end
      TOB_RUN: cnt_next = cnt_reg;
      default: state_next = TOB_LOAD;
    endcase
  end
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      state_reg <= TOB_LOAD;
      cnt_reg <= 6'h0;
      cnt_prev_reg <= 6'h0;
      prev_rd_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      cnt_prev_reg <= cnt_reg;
      prev_rd_reg <= state_reg == TOB_LOAD;
    end
  end
  assign flash_addr = cnt_reg;
  assign flash_rd = state_reg == TOB_LOAD;
  assign load_done = state_reg == TOB_RUN;

  // software writes keep reserved bits set where they must read one
  always_comb
  begin
    trim_wval = reg_wdata;
    if (trim_index_register_reg == `TOB_TRIM_CLKFLT)
      trim_wval = reg_wdata | `TOB_CLKFLT_RSVD; // RULE12
    else if (trim_index_register_reg == `TOB_TRIM_BROWN)
      trim_wval = reg_wdata | `TOB_BROWN_RSVD; // RULE12
  end

  // trim array has no reset: values come from flash, filter byte excepted
  always_ff @(posedge clock)
  begin
    if (prev_rd_reg && cnt_prev_reg >= `TOB_INFO_BASE)
      trim_mem_reg[cnt_prev_reg[4:0]] <= flash_data; // RULE11
    else if (wr_data)
      trim_mem_reg[trim_index_register_reg] <= trim_wval; // RULE10
  end

  always_comb
  begin
    trim_index_register_next = trim_index_register_reg;
    if (wr_idx)
      trim_index_register_next = reg_wdata[4:0]; // RULE10
    rdata_next = 8'h00;
    if (reg_sel && reg_rd && reg_addr == `TOB_IDX_ADDR)
      rdata_next = {3'h0, trim_index_register_reg};
    else if (reg_sel && reg_rd && reg_addr == `TOB_DATA_ADDR)
    begin
      rdata_next = trim_mem_reg[trim_index_register_reg]; // RULE10
      // filter byte is unset memory until load count 38 writes it
      if (trim_index_register_reg == `TOB_TRIM_CLKFLT)
        rdata_next = clkflt; // RULE5
    end
  end
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      trim_index_register_reg <= 5'h00;
      rdata_reg <= 8'h00;
    end
    else
    begin
      trim_index_register_reg <= trim_index_register_next;
      rdata_reg <= rdata_next;
    end
  end
  assign reg_rdata = rdata_reg;

  // filter byte reads its reset pattern until one clock after load_done rises, after the whole load has ended
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      clkflt_loaded_reg <= 1'b0;
    else if (load_done)
      clkflt_loaded_reg <= 1'b1;
  end
  assign clkflt = clkflt_loaded_reg ? trim_mem_reg[`TOB_TRIM_CLKFLT]
    : `TOB_CLKFLT_RESET; // RULE5

  assign filt_cfg.quarter_rate_select = clkflt[`TOB_DIV_BIT]; // RULE6
  assign filt_cfg.mode = tob_mode_t'({clkflt[`TOB_MODE_B1],
    clkflt[`TOB_MODE_B0]}); // RULE7
  assign filt_cfg.delay_code = {clkflt[`TOB_DLY_B2], clkflt[`TOB_DLY_B1],
    clkflt[`TOB_DLY_B0]}; // RULE8

  tob_clock_glitch_filter u_filter
  (
    .clock(clock),
    .rst(rst),
    .cfg(filt_cfg.filt),
    .clk_in(clk_in),
    .clk_out(clk_out)
  );

  // analog trim outputs; zero until loaded so nothing is undefined
  always_comb
  begin
    adc_reference_trim_field = 4'h0;
    adc_comparator_trim = 8'h00;
    precision_osc_trim_field = 8'h00;
    brownout_level_field = 3'h0;
    if (clkflt_loaded_reg)
    begin
      adc_reference_trim_field = trim_mem_reg[`TOB_TRIM_ADC_REF][7:4]; // RULE1
      adc_comparator_trim = trim_mem_reg[`TOB_TRIM_ADCCMP]; // RULE2
      precision_osc_trim_field = trim_mem_reg[`TOB_TRIM_OSC]; // RULE3
      brownout_level_field = trim_mem_reg[`TOB_TRIM_BROWN][2:0]; // RULE4
    end
  end
endmodule

// >>> tb/tob_bank_sva.sv
// port assertions for the trim option bank
`timescale 1ns/100ps
module tob_bank_sva
(
  input wire logic clock,
  input wire logic rst,
  input wire logic reg_sel,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic [5:0] flash_addr,
  input wire logic flash_rd,
  input wire logic load_done,
  input wire logic [3:0] adc_reference_trim_field,
  input wire logic [7:0] precision_osc_trim_field,
  input wire logic [2:0] brownout_level_field
);
  logic [7:0] idx_reg;
  logic dw;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // mirror of the index, to tie data writes to one trim byte
  always_ff @(posedge clock or posedge rst)
    if (rst)
      idx_reg <= 8'h00;
    else if (reg_sel && reg_wr && reg_addr == 8'h00)
      idx_reg <= reg_wdata;
  assign dw = reg_sel && reg_wr && reg_addr == 8'h01 && load_done;
  // the release edge itself still holds the counter in reset
  a_addr_step: assert property (!rst && flash_rd && !load_done
    && flash_addr < 6'h2a |=> flash_addr == $past(flash_addr) + 6'h01)
    else $error("bad step");
  a_load_end: assert property (flash_rd && flash_addr == 6'h2a
    |=> load_done && !flash_rd) else $error("load end");
  a_done_holds: assert property (load_done |=> load_done)
    else $error("done fell");
  a_read_answer: assert property (reg_rdata != 8'h00
    |-> $past(reg_rd) && $past(reg_sel)) else $error("stray data");
  a_unmapped_zero: assert property (reg_sel && reg_rd
    && reg_addr > 8'h01 |=> reg_rdata == 8'h00)
    else $error("unmapped read");
  a_adc_reference_trim_write: assert property (dw && idx_reg == 8'h00
    |=> {adc_reference_trim_field, 4'h0} == ($past(reg_wdata) & 8'hf0))
    else $error("adc ref write");
  a_osc_write: assert property (dw && idx_reg == 8'h02
    |=> precision_osc_trim_field == $past(reg_wdata))
    else $error("osc write");
  a_brown_write: assert property (dw && idx_reg == 8'h03
    |=> {5'h00, brownout_level_field} == ($past(reg_wdata) & 8'h07))
    else $error("brownout write");
  a_quiet_load: assert property (!load_done
    |-> adc_reference_trim_field == 4'h0) else $error("early trim");
endmodule
bind tob_trim_option_bank tob_bank_sva tob_bank_sva_inst (.*);

// >>> tb/testbench.sv
// self-checking bench for the trim option bank
`timescale 1ns/100ps
module testbench;
  logic clock = 1'b0, rst = 1'b1, reg_sel = 1'b0, reg_wr = 1'b0;
  logic reg_rd = 1'b0, clk_in = 1'b0, inv = 1'b0, out_q = 1'b0;
  logic [3:0] pw = 4'h0;
  int glitch_ns [8] = '{5, 7, 9, 11, 13, 17, 20, 25};
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, flash_data = 8'h00;
  logic [7:0] reg_rdata, adc_comparator_trim, precision_osc_trim_field;
  logic [5:0] flash_addr;
  logic flash_rd, load_done, clk_out;
  logic [3:0] adc_reference_trim_field, ph = 4'h0;
  logic [2:0] brownout_level_field;
  logic [7:0] rises = 8'h00, r0;
  logic [7:0] idx [5] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h06};
  int error_cnt = 0, checks = 0;
  tob_trim_option_bank tob_trim_option_bank_inst (.*);
  function automatic logic [7:0] img(input logic [5:0] a);
    case (a)
      6'h20: img = 8'ha5;
      6'h21: img = 8'h3c;
      6'h22: img = 8'h81;
      6'h23: img = 8'hfd;
      6'h26: img = 8'h6c;
      default: img = {2'b10, a};
    endcase
  endfunction
  always #2 clock = ~clock;
  // flash answers a cycle late; pw nonzero gives pw-cycle spikes
  always @(posedge clock)
  begin
    flash_data <= img(flash_addr);
    ph <= ph + 4'h1;
    clk_in <= pw == 4'h0 ? ph[3] : inv ^ (ph >= 4'h2 && ph < 4'h2 + pw);
    out_q <= clk_out;
    if (clk_out && !out_q)
      rises <= rises + 8'h01;
  end
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_sel <= 1'b1;
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_sel <= 1'b0;
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_sel <= 1'b1;
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_sel <= 1'b0;
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask
  // edge count over 320 cycles, i.e. 20 input periods
  task filt(input logic [7:0] c, input logic [7:0] lo, input logic [7:0] hi);
    wr(8'h00, 8'h06);
    wr(8'h01, c);
    rd(8'h01, c | 8'h44);
    repeat (40) @(posedge clock);
    r0 = rises;
    repeat (320) @(posedge clock);
    r0 = rises - r0;
    chk({7'h00, r0 >= lo && r0 <= hi}, 8'h01);
  endtask
  task print_verdict();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge clock);
    rst <= 1'b0;
    wr(8'h00, 8'h06);
    rd(8'h01, 8'h44);
    wr(8'h01, 8'h00);
    for (int i = 0; i < 60 && !load_done; i++)
      @(posedge clock);
    #1 chk({7'h00, load_done}, 8'h01);
    // byte 01h is only read back, never rewritten
    foreach (idx[k])
    begin
      wr(8'h00, idx[k]);
      rd(8'h01, img(6'h20 + idx[k][5:0]));
    end
    chk({adc_reference_trim_field, 4'h0}, 8'ha0);
    chk(adc_comparator_trim, 8'h3c);
    chk(precision_osc_trim_field, 8'h81);
    chk({5'h00, brownout_level_field}, 8'h05);
    $display("test load done");
    wr(8'h00, 8'h00);
    wr(8'h01, 8'h50);
    wr(8'h00, 8'h03);
    wr(8'h01, 8'h02);
    rd(8'h01, 8'hfa);
    wr(8'h00, 8'h02);
    wr(8'h01, 8'h7e);
    rd(8'h05, 8'h00);
    chk({adc_reference_trim_field, 4'h0}, 8'h50);
    chk(precision_osc_trim_field, 8'h7e);
    chk({5'h00, brownout_level_field}, 8'h02);
    $display("test regs done");
    filt(8'h00, 8'h13, 8'h15);
    filt(8'h80, 8'h04, 8'h06);
    pw <= 4'h1;
    // high spikes die in modes 10 and 11, low spikes in 01 and 11
    for (int m = 0; m < 8; m++)
    begin
      inv <= m[2];
      filt({6'h0e, m[1:0]}, (m[2] ? m[0] : m[1]) ? 8'h00 : 8'h13,
        (m[2] ? m[0] : m[1]) ? 8'h00 : 8'h15);
    end
    inv <= 1'b0;
    // 4 ns clock: a spike as wide as the limit dies, one cycle more passes
    for (int c = 0; c < 16; c++)
    begin
      pw <= 4'(glitch_ns[c[3:1]] / 4 + c[0]);
      filt({2'b00, c[1], c[2], c[3], 3'b011}, c[0] ? 8'h13 : 8'h00,
        c[0] ? 8'h15 : 8'h00);
    end
    $display("test filter done");
    print_verdict();
  end
  initial
  begin
    repeat (20000) @(posedge clock);
    error_cnt++;
    print_verdict();
  end
endmodule
